// *** mxc_sequencer.sv ***
// sequencer, timing and trim registers of the multiplexed converter
// assumes the host interface delivers decoded register reads and writes
// on clk, and that the ready pin is asynchronous to clk
`timescale 1ns/100ps
module mxc_sequencer (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,                    // freezes all state when low
   input  wire logic [7:0]  reg_addr,              // register index
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,                // one-cycle write strobe
   input  wire logic        reg_rd,                // one-cycle read strobe
   input  wire logic        sequence_launch_bit,   // one-cycle launch pulse
   input  wire logic        mux_converter_enable,
   input  wire logic        standby,               // standby or power-down
   input  wire logic        primary_conv_ready_n,  // asynchronous pin
   input  wire logic [3:0]  step_enable,           // per-step enables
   input  wire logic [7:0]  step_gain,             // 2 bits per step
   input  wire logic [15:0] conv_raw,              // raw sample at conversion end
   output logic      [15:0] reg_rdata,
   output logic      [15:0] conv_result,
   output logic      [1:0]  sequence_step_counter,
   output logic             seq_busy,
   output logic             converting
);
   // ==========================================================
   // state
   logic [1:0]  mode_reg, mode_next;                // sequencer_start_mode
   logic [2:0]  delay_reg, delay_next;              // step_settle_delay
   logic [1:0]  osr_reg, osr_next;                  // oversample_ratio_select
   logic [7:0]  spare_reg, spare_next;              // spare storage
   logic [15:0] offset_reg, offset_next;            // offset_trim_value
   logic [15:0] gain_reg, gain_next;                // gain_trim_value
   logic [15:0] rdata_reg, rdata_next;              // read answer
   logic [15:0] result_reg, result_next;            // corrected result
   logic [1:0]  step_reg, step_next;                // sequence_step_counter
   logic [12:0] cnt_reg, cnt_next;                  // settle/convert counter
   logic        conv_reg, conv_next;                // converting flag
   logic        busy_reg, busy_next;
   logic [2:0]  rdy_sync_reg, rdy_sync_next;        // sync then edge stage
   mxc_pkg::mxc_state_t state_reg, state_next;

   logic        active;      // enabled and not in standby
   logic        ready_fall;  // falling edge of synchronised ready
   logic [2:0]  first_hit;   // {found, index} from step 0
   logic [2:0]  next_hit;    // {found, index} after current step
   logic [15:0] corrected;

   // ==========================================================
   // helpers
   // search for the first enabled step at or above a start index
   function automatic logic [2:0] find_step(input logic [3:0] en,
                                            input logic [2:0] from);
      logic [2:0] hit;
      hit = 3'h0;
      for (int i = 3; i >= 0; i--) begin
         if (en[i] && (3'(i) >= from)) begin
            hit = {1'b1, 2'(i)};
         end
      end
      return hit;
   endfunction : find_step

   // settle delay load value for a code
   function automatic logic [12:0] settle_load(input logic [2:0] code);
      return mxc_pkg::SETTLE_CYC[code] - 13'h0001;
   endfunction : settle_load

   // step search is combinational; four steps keep it shallow
   assign active     = mux_converter_enable && !standby;
   assign ready_fall = rdy_sync_reg[2] && !rdy_sync_reg[1];
   assign first_hit  = find_step(step_enable, 3'h0);
   assign next_hit   = find_step(step_enable, {1'b0, step_reg} + 3'h1);

   // correction works on the live raw input, the last convert cycle only registers it
   mxc_trim u_trim (
      .raw         (conv_raw),
      .offset_trim (offset_reg),
      .gain_trim   (gain_reg),
      .half_step   (step_gain[{step_reg, 1'b0} +: 2] != 2'h0),
      .corrected   (corrected)
   );

   // ==========================================================
   // register file next values
   // writes land at the strobe's edge; a read answers at that same edge
   always_comb begin
      mode_next   = mode_reg;
      delay_next  = delay_reg;
      osr_next    = osr_reg;
      spare_next  = spare_reg;
      offset_next = offset_reg;
      gain_next   = gain_reg;
      rdata_next  = rdata_reg;
      // writes: reserved bits simply not stored
      if (reg_wr) begin
         unique case (reg_addr)
            mxc_pkg::ADDR_SEQ_CFG: begin
               mode_next  = reg_wdata[mxc_pkg::MODE_LSB +: 2];
               delay_next = reg_wdata[mxc_pkg::DELAY_LSB +: 3];
               osr_next   = reg_wdata[mxc_pkg::OSR_LSB +: 2];
            end
            mxc_pkg::ADDR_SPARE:       spare_next  = reg_wdata[7:0];
            mxc_pkg::ADDR_OFFSET_TRIM: offset_next = reg_wdata;
            mxc_pkg::ADDR_GAIN_TRIM:   gain_next   = reg_wdata;
            default: ;  // other addresses belong elsewhere
         endcase
      end
      // reads: reserved fields and unknown addresses give zero
      if (reg_rd) begin
         unique case (reg_addr)
            mxc_pkg::ADDR_SEQ_CFG:
               rdata_next = {mode_reg, 3'h0, delay_reg, 6'h00, osr_reg};
            mxc_pkg::ADDR_SPARE:       rdata_next = {8'h00, spare_reg};
            mxc_pkg::ADDR_OFFSET_TRIM: rdata_next = offset_reg;
            mxc_pkg::ADDR_GAIN_TRIM:   rdata_next = gain_reg;
            default:                   rdata_next = 16'h0000;
         endcase
      end
   end

   // register flops; reset wins over ce, ce low freezes them
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_reg   <= mxc_pkg::RST_MODE;
         delay_reg  <= mxc_pkg::RST_DELAY;
         osr_reg    <= mxc_pkg::RST_OSR;
         spare_reg  <= mxc_pkg::RST_SPARE;
         offset_reg <= mxc_pkg::RST_TRIM;
         gain_reg   <= mxc_pkg::RST_TRIM;
         rdata_reg  <= 16'h0000;
      end else if (ce) begin
         mode_reg   <= mode_next;
         delay_reg  <= delay_next;
         osr_reg    <= osr_next;
         spare_reg  <= spare_next;
         offset_reg <= offset_next;
         gain_reg   <= gain_next;
         rdata_reg  <= rdata_next;
      end
   end

   // ==========================================================
   // sequencer next values
   // a step settles for the selected delay, converts with converting high,
   // then spends one store cycle; a launch wins over every state except
   // disable, which drops the sequence and clears the result
   always_comb begin
      state_next    = state_reg;
      step_next     = step_reg;
      cnt_next      = cnt_reg;
      result_next   = result_reg;
      conv_next     = 1'b0;
      rdy_sync_next = {rdy_sync_reg[1:0], primary_conv_ready_n};
      if (!active) begin
         // disabled or standby drops everything
         state_next  = mxc_pkg::ST_IDLE;
         step_next   = 2'h0;
         result_next = mxc_pkg::RST_RESULT;
      end else if (sequence_launch_bit) begin
         // launch always aborts; it begins at the first enabled step, or idles if none is
         if (first_hit[2]) begin
            state_next = mxc_pkg::ST_SETTLE;
            step_next  = first_hit[1:0];
            cnt_next   = settle_load(delay_reg);
         end else begin
            state_next = mxc_pkg::ST_IDLE;
         end
      end else begin
         unique case (state_reg)
            mxc_pkg::ST_IDLE: begin
               // ready edges only count when idle
               if (mode_reg == mxc_pkg::MODE_READY && ready_fall && first_hit[2]) begin
                  state_next = mxc_pkg::ST_SETTLE;
                  step_next  = first_hit[1:0];
                  cnt_next   = settle_load(delay_reg);
               end
            end
            mxc_pkg::ST_SETTLE: begin
               if (cnt_reg == 13'h0000) begin
                  // settling done, start the step's conversion
                  state_next = mxc_pkg::ST_CONVERT;
                  cnt_next   = mxc_pkg::CONV_CYC[osr_reg] - 13'h0001;
                  conv_next  = 1'b1;
               end else begin
                  cnt_next = cnt_reg - 13'h0001;
               end
            end
            mxc_pkg::ST_CONVERT: begin
               if (cnt_reg == 13'h0000) begin
                  result_next = corrected;
                  state_next  = mxc_pkg::ST_STORE;
               end else begin
                  cnt_next  = cnt_reg - 13'h0001;
                  conv_next = 1'b1;
               end
            end
            mxc_pkg::ST_STORE: begin
               if (next_hit[2]) begin
                  // switch input selection, then settle
                  state_next = mxc_pkg::ST_SETTLE;
                  step_next  = next_hit[1:0];
                  cnt_next   = settle_load(delay_reg);
               end else if (mode_reg[1] && first_hit[2]) begin
                  state_next = mxc_pkg::ST_SETTLE;
                  step_next  = first_hit[1:0];
                  cnt_next   = settle_load(delay_reg);
               end else begin
                  state_next = mxc_pkg::ST_IDLE;
               end
            end
         endcase
      end
      busy_next = (state_next != mxc_pkg::ST_IDLE);
   end

   // sequencer flops; synchroniser preset high, so no false edge at reset
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg    <= mxc_pkg::ST_IDLE;
         step_reg     <= 2'h0;
         cnt_reg      <= 13'h0000;
         result_reg   <= mxc_pkg::RST_RESULT;
         conv_reg     <= 1'b0;
         busy_reg     <= 1'b0;
         rdy_sync_reg <= 3'h7;
      end else if (ce) begin
         state_reg    <= state_next;
         step_reg     <= step_next;
         cnt_reg      <= cnt_next;
         result_reg   <= result_next;
         conv_reg     <= conv_next;
         busy_reg     <= busy_next;
         rdy_sync_reg <= rdy_sync_next;
      end
   end

   // every output straight from a flop
   assign reg_rdata             = rdata_reg;
   assign conv_result           = result_reg;
   assign sequence_step_counter = step_reg;
   assign seq_busy              = busy_reg;
   assign converting            = conv_reg;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   launch_restart_a: assert property (ce && active && sequence_launch_bit && first_hit[2]
      |=> state_reg == mxc_pkg::ST_SETTLE && cnt_reg == settle_load(delay_reg))
      else $error("launch did not restart the sequence");
   single_stop_a: assert property (ce && active && !sequence_launch_bit
      && state_reg == mxc_pkg::ST_STORE && !next_hit[2] && !mode_reg[1]
      |=> state_reg == mxc_pkg::ST_IDLE)
      else $error("single-shot sequence did not stop");
   cont_repeat_a: assert property (ce && active && !sequence_launch_bit
      && state_reg == mxc_pkg::ST_STORE && !next_hit[2] && mode_reg[1] && first_hit[2]
      |=> state_reg == mxc_pkg::ST_SETTLE && step_reg == first_hit[1:0])
      else $error("continuous sequence did not repeat");
   ready_start_a: assert property (ce && active && !sequence_launch_bit
      && state_reg == mxc_pkg::ST_IDLE && mode_reg == mxc_pkg::MODE_READY
      && $fell(rdy_sync_reg[1]) && first_hit[2]
      |=> state_reg == mxc_pkg::ST_SETTLE)
      else $error("ready edge did not start a sequence");
   ready_ignore_a: assert property (ce && active && !sequence_launch_bit
      && state_reg == mxc_pkg::ST_SETTLE && cnt_reg != 13'h0000 && ready_fall
      |=> cnt_reg == $past(cnt_reg) - 13'h0001)
      else $error("ready edge disturbed a running sequence");
   conv_length_a: assert property (ce && active && !sequence_launch_bit
      && state_reg == mxc_pkg::ST_SETTLE && cnt_reg == 13'h0000
      |=> converting && cnt_reg == mxc_pkg::CONV_CYC[osr_reg] - 13'h0001)
      else $error("conversion length wrong");
   settle_load_a: assert property (ce && active && !sequence_launch_bit
      && state_reg == mxc_pkg::ST_STORE && next_hit[2]
      |=> state_reg == mxc_pkg::ST_SETTLE
      && cnt_reg == mxc_pkg::SETTLE_CYC[delay_reg] - 13'h0001)
      else $error("settle delay not loaded at step switch");
   trim_store_a: assert property (ce && active && !sequence_launch_bit
      && state_reg == mxc_pkg::ST_CONVERT && cnt_reg == 13'h0000
      |=> conv_result == $past(corrected))
      else $error("corrected result not stored");
   disable_clear_a: assert property (ce && !active
      |=> conv_result == 16'h0000 && sequence_step_counter == 2'h0 && !seq_busy)
      else $error("disable did not clear data and step");
   reserved_zero_a: assert property (ce && reg_rd && !reg_wr
      && reg_addr == mxc_pkg::ADDR_SEQ_CFG
      |=> reg_rdata[13:11] == 3'h0 && reg_rdata[7:2] == 6'h00)
      else $error("reserved bits read nonzero");

   // ce low must freeze the sequencer completely
   freeze_hold_a: assert property (!ce
      |=> $stable(state_reg) && $stable(cnt_reg) && $stable(step_reg))
      else $error("sequencer state moved while ce was low");
   empty_launch_a: assert property (
      ce && active && sequence_launch_bit && !first_hit[2] |=> !seq_busy)
      else $error("launch with no step enabled left the sequencer busy");
   pin_ignore_a: assert property (ce && active && !sequence_launch_bit
      && state_reg == mxc_pkg::ST_IDLE && mode_reg != mxc_pkg::MODE_READY
      |=> state_reg == mxc_pkg::ST_IDLE)
      else $error("sequence started without a launch outside ready mode");

endmodule : mxc_sequencer

// *** mxc_pkg.sv ***
// package of constants for the multiplexed converter sequencer and trim block
// assumes one 125 MHz clock that also serves as the converter master clock
// How it works
// - mode 00b: one sequence per launch bit
// - launch bit always aborts and restarts sequence; with no step enabled it only aborts to idle
// - mode 01b: ready falling edge or launch starts
// - mode 01b: ready edges ignored while sequence runs
// - modes 10b/11b repeat sequences after first launch
// - settle delay 16 to 4096 clocks per code
// - oversample code sets 384/512/768/1280 clock conversions
// - reserved bits ignore writes, read zero
// - spare low byte is plain storage
// - offset trim 16-bit signed, resets to zero
// - offset step halves for step gain 2 or 4
// - gain trim register at 8Fh, resets zero
// - gain factor is one plus value over 2^16
// - disable or standby clears data and step counter
package mxc_pkg;

   // ==========================================================
   // register map
   localparam logic [7:0] ADDR_SEQ_CFG     = 8'h8C;  // sequence config
   localparam logic [7:0] ADDR_SPARE       = 8'h8D;  // spare storage
   localparam logic [7:0] ADDR_OFFSET_TRIM = 8'h8E;  // offset trim
   localparam logic [7:0] ADDR_GAIN_TRIM   = 8'h8F;  // gain trim

   // ==========================================================
   // field positions of the sequence config register
   localparam int MODE_LSB  = 14;  // sequencer_start_mode [15:14]
   localparam int DELAY_LSB = 8;   // step_settle_delay [10:8]
   localparam int OSR_LSB   = 0;   // oversample_ratio_select [1:0]
   localparam int SPARE_W   = 8;   // writable width of spare register

   // ==========================================================
   // reset values
   localparam logic [1:0]  RST_MODE   = 2'h0;
   localparam logic [2:0]  RST_DELAY  = 3'h0;
   localparam logic [1:0]  RST_OSR    = 2'h0;
   localparam logic [7:0]  RST_SPARE  = 8'h00;
   localparam logic [15:0] RST_TRIM   = 16'h0000;
   localparam logic [15:0] RST_RESULT = 16'h0000;

   // ==========================================================
   // start modes
   localparam logic [1:0] MODE_SINGLE = 2'h0;  // one shot on launch bit
   localparam logic [1:0] MODE_READY  = 2'h1;  // one shot on ready edge

   // ==========================================================
   // timing counts in master clock periods
   localparam int CNT_W = 13;
   localparam logic [CNT_W-1:0] SETTLE_CYC [8] = '{
      13'h0010, 13'h0040, 13'h0080, 13'h0100,
      13'h0200, 13'h0400, 13'h0800, 13'h1000};
   localparam logic [CNT_W-1:0] CONV_CYC [4] = '{
      13'h0180, 13'h0200, 13'h0300, 13'h0500};

   // ==========================================================
   // sequencer states, gray along idle-settle-convert-store
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_SETTLE  = 2'b01,
      ST_CONVERT = 2'b11,
      ST_STORE   = 2'b10
   } mxc_state_t;

endpackage : mxc_pkg

// *** mxc_trim.sv ***
// offset and gain correction of one raw conversion result
// assumes raw result and trims are stable; purely combinational
`timescale 1ns/100ps
module mxc_trim (
   input  wire logic [15:0] raw,
   input  wire logic [15:0] offset_trim,
   input  wire logic [15:0] gain_trim,
   input  wire logic        half_step,
   output logic      [15:0] corrected
);
   logic signed [16:0] off_eff;   // offset in result codes
   logic signed [16:0] diff;      // raw minus offset
   logic signed [17:0] factor;    // 2^16 plus gain trim
   logic signed [34:0] prod;      // full product
   logic signed [34:0] scaled;    // product back to result scale

   // ==========================================================
   // correction
   always_comb begin
      // finer offset step at step gain 2 or 4
      off_eff = half_step ? ($signed({offset_trim[15], offset_trim}) >>> 1)
                          : $signed({offset_trim[15], offset_trim});
      diff    = $signed({raw[15], raw}) - off_eff;
      factor  = $signed({2'b01, 16'h0000}) + $signed({{2{gain_trim[15]}}, gain_trim});
      prod    = 35'(diff * factor);
      scaled  = prod >>> 16;
      // saturate rather than wrap at full scale
      if (scaled > 35'sh0_0000_7FFF) begin
         corrected = 16'h7FFF;
      end else if (scaled < -35'sh0_0000_8000) begin
         corrected = 16'h8000;
      end else begin
         corrected = scaled[15:0];
      end
   end
endmodule : mxc_trim

// *** mux_adc_sequencer_config_tb_top.sv ***
// self-checking bench for the multiplexed converter sequencer and trim block
// assumes mxc_pkg and mxc_sequencer are compiled first; the bench stands in
// for the host interface, the start bit, the ready pin and the raw samples
`timescale 1ns/100ps
module mux_adc_sequencer_config_tb_top;

   // ==========================================================
   // stimulus and observed signals
   logic        clk                  = 1'b0;
   logic        rst                  = 1'b1;
   logic        ce                   = 1'b1;      // low freezes the block
   logic [7:0]  reg_addr             = 8'h00;
   logic [15:0] reg_wdata            = 16'h0000;
   logic        reg_wr               = 1'b0;
   logic        reg_rd               = 1'b0;
   logic        sequence_launch_bit  = 1'b0;
   logic        mux_converter_enable = 1'b1;
   logic        standby              = 1'b0;
   logic        primary_conv_ready_n = 1'b1;      // idle high, no false edge
   logic [3:0]  step_enable          = 4'h1;
   logic [7:0]  step_gain            = 8'h00;
   logic [15:0] conv_raw             = 16'h1234;
   logic [15:0] reg_rdata;
   logic [15:0] conv_result;
   logic [1:0]  sequence_step_counter;
   logic        seq_busy;
   logic        converting;
   int          fails                = 0;         // mismatches
   int          cmp_count            = 0;         // comparisons made
   int          settle_exp [8]       = '{16, 64, 128, 256, 512, 1024, 2048, 4096};
   int          conv_exp   [4]       = '{384, 512, 768, 1280};

   // ==========================================================
   // clock, 8 ns period
   always #4 clk = ~clk;

   mxc_sequencer dut (
      .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .sequence_launch_bit(sequence_launch_bit),
      .mux_converter_enable(mux_converter_enable), .standby(standby),
      .primary_conv_ready_n(primary_conv_ready_n), .step_enable(step_enable),
      .step_gain(step_gain), .conv_raw(conv_raw), .reg_rdata(reg_rdata),
      .conv_result(conv_result), .sequence_step_counter(sequence_step_counter),
      .seq_busy(seq_busy), .converting(converting));

   // ==========================================================
   // helpers; every task starts and ends just after a falling edge
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test

   // compare with case inequality so an unknown never matches
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   // config is only changed with the converter disabled, as software must
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      mux_converter_enable = 1'b0;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      mux_converter_enable = 1'b1;
      @(negedge clk);
   endtask : wr

   // one read strobe, answer sampled a full cycle later (it stands)
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      @(negedge clk);
      chk("register read", e, reg_rdata);
   endtask : rd

   function automatic logic [15:0] cfg(input logic [1:0] m, input logic [2:0] d,
                                       input logic [1:0] o);
      return {m, 3'h0, d, 6'h00, o};
   endfunction : cfg

   task automatic launch;
      sequence_launch_bit = 1'b1;
      @(negedge clk);
      sequence_launch_bit = 1'b0;
   endtask : launch

   // src 0 start bit, 1 ready pin, 2 no start (next step or repeat);
   // the pin is pulsed in every settle phase, which must never restart it
   task automatic run_seq(input int src, input int es, input int ec,
                          input logic [1:0] stp, input logic [15:0] res);
      int ns;
      int nc;
      ns = 0;
      nc = 0;
      if (src == 0) launch();
      if (src == 1) begin
         primary_conv_ready_n = 1'b1;
         repeat (4) @(negedge clk);
         primary_conv_ready_n = 1'b0;
         while (seq_busy !== 1'b1 && ns < 8) begin
            ns++;
            @(negedge clk);
         end
         chk("pin start", 16'h0001, {15'h0000, ns < 8});
         ns = 0;
      end
      while (converting !== 1'b1 && ns < 9000) begin
         if (ns == 8) primary_conv_ready_n = 1'b1;
         if (ns == 12) primary_conv_ready_n = 1'b0;
         ns++;
         @(negedge clk);
      end
      if (src != 2) chk("settle cycles", es[15:0], ns[15:0]);
      chk("step index", {14'h0000, stp}, {14'h0000, sequence_step_counter});
      while (converting === 1'b1 && nc < 9000) begin
         nc++;
         @(negedge clk);
      end
      chk("conversion cycles", ec[15:0], nc[15:0]);
      @(negedge clk);
      chk("result", res, conv_result);
   endtask : run_seq

   // ==========================================================
   // watchdog, well above the roughly 20k cycles the tests need
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      $display("ERROR watchdog expected 0 seen 1");
      stop_test();
   end

   // ==========================================================
   // main sequence
   initial begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      // reset values, reserved bits, unmapped place
      for (int i = 0; i < 4; i++) rd(8'h8C + 8'(i), 16'h0000);
      wr(8'h8C, 16'hFFFF);
      rd(8'h8C, 16'hC703);
      wr(8'h8D, 16'hFFFF);
      rd(8'h8D, 16'h00FF);
      wr(8'h8E, 16'hA5C3);
      rd(8'h8E, 16'hA5C3);
      wr(8'h8F, 16'h5A3C);
      rd(8'h8F, 16'h5A3C);
      wr(8'h90, 16'hFFFF);
      rd(8'h90, 16'h0000);
      wr(8'h8E, 16'h0000);
      wr(8'h8F, 16'h0000);
      // every delay code and every oversample code, single shot
      for (int i = 0; i < 8; i++) begin
         wr(8'h8C, cfg(2'h0, 3'(i), 2'(i)));
         run_seq(0, settle_exp[i], conv_exp[i % 4], 2'h0, 16'h1234);
         repeat (2) @(negedge clk);
         chk("busy after single", 16'h0000, {15'h0000, seq_busy});
      end
      // restart in settle and in conversion
      wr(8'h8C, cfg(2'h0, 3'h3, 2'h0));
      launch();
      repeat (100) @(negedge clk);
      run_seq(0, 256, 384, 2'h0, 16'h1234);
      wr(8'h8C, cfg(2'h0, 3'h0, 2'h0));
      launch();
      repeat (30) @(negedge clk);
      run_seq(0, 16, 384, 2'h0, 16'h1234);
      // ce low freezes a running settle and swallows a launch pulse
      launch();
      repeat (4) @(negedge clk);
      ce = 1'b0;
      repeat (40) @(negedge clk);
      chk("busy frozen", 16'h0001, {15'h0000, seq_busy});
      chk("converting frozen", 16'h0000, {15'h0000, converting});
      ce = 1'b1;
      run_seq(0, 16, 384, 2'h0, 16'h1234);
      ce = 1'b0;
      launch();
      ce = 1'b1;
      repeat (2) @(negedge clk);
      chk("launch while frozen", 16'h0000, {15'h0000, seq_busy});
      // launch with no step enabled aborts to idle
      launch();
      repeat (30) @(negedge clk);
      step_enable = 4'h0;
      launch();
      repeat (2) @(negedge clk);
      chk("busy empty launch", 16'h0000, {15'h0000, seq_busy});
      step_enable = 4'h1;
      // ready pin start, ignored while running, one shot
      wr(8'h8C, cfg(2'h1, 3'h0, 2'h0));
      run_seq(1, 16, 384, 2'h0, 16'h1234);
      repeat (3) @(negedge clk);
      chk("busy after pin shot", 16'h0000, {15'h0000, seq_busy});
      // continuous modes repeat, then disable clears everything
      for (int m = 2; m < 4; m++) begin
         wr(8'h8C, cfg(2'(m), 3'h0, 2'h0));
         run_seq(0, 16, 384, 2'h0, 16'h1234);
         run_seq(2, 0, 384, 2'h0, 16'h1234);
         mux_converter_enable = 1'b0;
         repeat (2) @(negedge clk);
         chk("result disabled", 16'h0000, conv_result);
         chk("busy disabled", 16'h0000, {15'h0000, seq_busy});
         mux_converter_enable = 1'b1;
      end
      // two steps in ascending order, then standby mid-sequence
      wr(8'h8C, cfg(2'h0, 3'h0, 2'h0));
      step_enable = 4'hA;
      run_seq(0, 16, 384, 2'h1, 16'h1234);
      run_seq(2, 0, 384, 2'h3, 16'h1234);
      launch();
      repeat (30) @(negedge clk);
      standby = 1'b1;
      repeat (2) @(negedge clk);
      chk("step standby", 16'h0000, {14'h0000, sequence_step_counter});
      chk("result standby", 16'h0000, conv_result);
      chk("busy standby", 16'h0000, {15'h0000, seq_busy});
      standby = 1'b0;
      // offset and gain correction, half offset step at step gain 2
      step_enable = 4'h1;
      conv_raw = 16'h1000;
      wr(8'h8E, 16'h0100);
      wr(8'h8F, 16'h8000);
      run_seq(0, 16, 384, 2'h0, 16'h0780);
      step_gain = 8'h01;
      run_seq(0, 16, 384, 2'h0, 16'h07C0);
      step_gain = 8'h00;
      wr(8'h8F, 16'h4000);
      run_seq(0, 16, 384, 2'h0, 16'h12C0);
      stop_test();
   end

endmodule : mux_adc_sequencer_config_tb_top
